// File: inc/modem_port_pkg.sv
package modem_port_pkg;

  // ****************************************************************
  // word framing
  // ****************************************************************
  localparam int WORD_BITS = 8;
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

  // ****************************************************************
  // power-on configuration
  // ****************************************************************
  // byte location of the burst length in non-volatile storage
  localparam logic [15:0] BURST_LENGTH_ADDR = 16'h0200;
  // factory value of that byte, in words
  localparam logic [7:0] BURST_LENGTH_DEFAULT = 8'h40;
  // clk cycles that the strap inputs settle after reset release before capture
  localparam logic [3:0] CONFIG_SETTLE_CYCLES = 4'h8;
  // level of the mode switch that selects continuous acquisition
  localparam logic SWITCH_ON = 1'b1;

  // ****************************************************************
  // bit clock generation
  // ****************************************************************
  // link_clk cycles per half period of the bit clocks
  localparam int BIT_CLOCK_HALF_DEFAULT = 4;
  // synchroniser pipe depth: a falling-edge sample is used this many cycles later
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // back-off adaptation
  // ****************************************************************
  // time constant of the amplifier back-off tracking, in symbols
  localparam int ADAPT_TIME_SYMBOLS = 128000;

  // ****************************************************************
  // reset values of pin-facing outputs
  // ****************************************************************
  localparam logic SYNC_INACTIVE = 1'b1;
  localparam logic IDLE_DATA = 1'b1;

endpackage

// File: hdl/bit_sync.sv
// two flip-flop synchroniser; the first stage feeds only the second
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      stage <= d;
      q <= stage;
    end
  end

endmodule

// File: hdl/modem_dte_serial_burst_port.sv
module modem_dte_serial_burst_port #(
  parameter int BIT_CLOCK_HALF = modem_port_pkg::BIT_CLOCK_HALF_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic acquisition_mode_switch,
  output logic [15:0] nv_config_addr,
  input wire logic [7:0] nv_config_data,
  output logic tx_bit_clock,
  input wire logic tx_serial_data,
  input wire logic tx_burst_sync_n,
  output logic rx_bit_clock,
  output logic rx_serial_data,
  output logic rx_burst_sync_n,
  output logic [7:0] tx_word,
  output logic tx_word_first,
  output logic tx_word_valid,
  input wire logic [7:0] rx_word,
  input wire logic rx_word_first,
  input wire logic rx_word_valid,
  output logic rx_word_ready,
  output logic config_done,
  output logic continuous_mode,
  output logic [7:0] burst_length,
  output logic backoff_adapt_enable
);

  // ****************************************************************
  // power-on configuration (clk domain)
  // ****************************************************************
  logic [8:0] strap_sync;
  logic [3:0] settle_count;

  bit_sync #(
    .WIDTH(9),
    .RESET_VALUE(9'h000)
  ) u_strap_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({acquisition_mode_switch, nv_config_data}),
    .q(strap_sync)
  );

  assign nv_config_addr = modem_port_pkg::BURST_LENGTH_ADDR;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_count <= 4'h0;
    end else if (settle_count != modem_port_pkg::CONFIG_SETTLE_CYCLES) begin
      settle_count <= settle_count + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_done <= 1'b0;
      continuous_mode <= 1'b0;
      burst_length <= modem_port_pkg::BURST_LENGTH_DEFAULT;
    end else if (!config_done && settle_count == modem_port_pkg::CONFIG_SETTLE_CYCLES) begin
      config_done <= 1'b1;
      continuous_mode <= (strap_sync[8] == modem_port_pkg::SWITCH_ON);
      burst_length <= strap_sync[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      backoff_adapt_enable <= 1'b0;
    end else begin
      backoff_adapt_enable <= config_done && continuous_mode;
    end
  end

  // ****************************************************************
  // crossings between the clk and link domains
  // ****************************************************************
  // mode and length are frozen once config_done rises, so only the flag needs a synchroniser
  logic link_cfg;
  logic rx_req;
  logic rx_req_link;
  logic rx_ack;
  logic rx_ack_sync;
  logic tx_req;
  logic tx_req_sync;
  logic [1:0] tx_pins;

  bit_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_cfg_sync (
    .clk(link_clk),
    .rst_b(rst_b),
    .d(config_done),
    .q(link_cfg)
  );

  bit_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_rx_req_sync (
    .clk(link_clk),
    .rst_b(rst_b),
    .d(rx_req),
    .q(rx_req_link)
  );

  bit_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_rx_ack_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(rx_ack),
    .q(rx_ack_sync)
  );

  bit_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_tx_req_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(tx_req),
    .q(tx_req_sync)
  );

  // open sync input reads high, matching the reset value
  bit_sync #(
    .WIDTH(2),
    .RESET_VALUE({modem_port_pkg::SYNC_INACTIVE, 1'b0})
  ) u_tx_pin_sync (
    .clk(link_clk),
    .rst_b(rst_b),
    .d({tx_burst_sync_n, tx_serial_data}),
    .q(tx_pins)
  );

  // ****************************************************************
  // receive word hand-off (clk domain)
  // ****************************************************************
  logic [7:0] rx_hold;
  logic rx_hold_first;
  logic tx_seen;
  logic [7:0] tx_hold;
  logic tx_hold_first;

  // one word in flight; ready again once the link side has acknowledged it
  assign rx_word_ready = config_done && (rx_req == rx_ack_sync);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_req <= 1'b0;
      rx_hold <= 8'h00;
      rx_hold_first <= 1'b0;
    end else if (rx_word_valid && rx_word_ready) begin
      rx_req <= ~rx_req;
      rx_hold <= rx_word;
      rx_hold_first <= rx_word_first;
    end
  end

  // ****************************************************************
  // transmit word delivery (clk domain)
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_seen <= 1'b0;
      tx_word <= 8'h00;
      tx_word_first <= 1'b0;
      tx_word_valid <= 1'b0;
    end else begin
      tx_word_valid <= 1'b0;
      if (tx_req_sync != tx_seen) begin
        tx_seen <= tx_req_sync;
        tx_word <= tx_hold;
        tx_word_first <= tx_hold_first;
        tx_word_valid <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // bit clock generation (link domain)
  // ****************************************************************
  logic [7:0] div_count;
  logic bit_clock;
  logic fall_now;
  logic [modem_port_pkg::SYNC_STAGES-1:0] sample_pipe;

  assign fall_now = bit_clock && (div_count == 8'(BIT_CLOCK_HALF - 1));

  // both bit clocks made here from link_clk
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_count <= 8'h00;
      bit_clock <= 1'b0;
    end else if (div_count == 8'(BIT_CLOCK_HALF - 1)) begin
      div_count <= 8'h00;
      bit_clock <= ~bit_clock;
    end else begin
      div_count <= div_count + 8'h01;
    end
  end

  assign tx_bit_clock = bit_clock;
  assign rx_bit_clock = bit_clock;

  // pins seen at a fall are out of the synchroniser this many cycles later
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_pipe <= '0;
    end else begin
      sample_pipe <= {sample_pipe[modem_port_pkg::SYNC_STAGES-2:0], fall_now};
    end
  end

  // ****************************************************************
  // transmit deserialiser (link domain)
  // ****************************************************************
  logic tx_sample;
  logic tx_data_bit;
  logic tx_sync_low;
  logic tx_active;
  logic tx_first;
  logic [2:0] tx_bit_index;
  logic [7:0] tx_shift;
  logic [7:0] tx_count;
  logic [7:0] next_tx_shift;

  // falling-edge sample, delayed through the synchroniser
  assign tx_sample = sample_pipe[modem_port_pkg::SYNC_STAGES-1] && link_cfg;
  assign tx_data_bit = tx_pins[0];
  // active sync is low at a transmit fall; ignored in continuous mode
  assign tx_sync_low = !tx_pins[1] && !continuous_mode;
  // shift left so the first bit lands as the most significant
  assign next_tx_shift = {tx_shift[6:0], tx_data_bit};

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_active <= 1'b0;
      tx_first <= 1'b0;
      tx_bit_index <= 3'h0;
      tx_shift <= 8'h00;
      tx_count <= 8'h00;
      tx_hold <= 8'h00;
      tx_hold_first <= 1'b0;
      tx_req <= 1'b0;
    end else if (tx_sample) begin
      if (tx_sync_low) begin
        // sync realigns the word; a burst starts if none was running
        tx_bit_index <= 3'h1;
        tx_shift <= next_tx_shift;
        if (!tx_active) begin
          tx_active <= 1'b1;
          tx_first <= 1'b1;
          tx_count <= 8'h00;
        end
      end else if (continuous_mode || tx_active) begin
        tx_shift <= next_tx_shift;
        tx_bit_index <= tx_bit_index + 3'h1;
        if (tx_bit_index == modem_port_pkg::LAST_BIT_INDEX) begin
          tx_hold <= next_tx_shift;
          tx_hold_first <= tx_first;
          tx_first <= 1'b0;
          tx_req <= ~tx_req;
          tx_count <= tx_count + 8'h01;
          // a burst ends after the configured words; zero means 256
          if (!continuous_mode && tx_count == burst_length - 8'h01) begin
            tx_active <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // receive serialiser (link domain)
  // ****************************************************************
  logic rx_pending;
  logic rx_active;
  logic rx_new_burst;
  logic [2:0] rx_bit_index;
  logic [7:0] rx_shift;
  logic [7:0] rx_count;

  assign rx_pending = rx_req_link != rx_ack;
  // coded or uncoded, a new burst opens at a gap, a first flag or a full count
  assign rx_new_burst = !rx_active || rx_hold_first || rx_count == burst_length - 8'h01;

  // data changes at the fall so the terminal samples on the rise
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ack <= 1'b0;
      rx_active <= 1'b0;
      rx_bit_index <= 3'h0;
      rx_shift <= 8'h00;
      rx_count <= 8'h00;
      rx_serial_data <= modem_port_pkg::IDLE_DATA;
      rx_burst_sync_n <= modem_port_pkg::SYNC_INACTIVE;
    end else if (fall_now && link_cfg) begin
      if (rx_bit_index != 3'h0) begin
        rx_serial_data <= rx_shift[7];
        rx_shift <= {rx_shift[6:0], 1'b0};
        rx_bit_index <= rx_bit_index + 3'h1;
        // sync back high with the second bit
        rx_burst_sync_n <= modem_port_pkg::SYNC_INACTIVE;
      end else if (rx_pending) begin
        // the hold word is stable: the clk side waits for this acknowledge
        rx_ack <= ~rx_ack;
        rx_serial_data <= rx_hold[7];
        rx_shift <= {rx_hold[6:0], 1'b0};
        rx_bit_index <= 3'h1;
        rx_active <= !continuous_mode;
        rx_count <= rx_new_burst ? 8'h00 : rx_count + 8'h01;
        // low for the first bit of every word in a burst; driven here
        rx_burst_sync_n <= continuous_mode;
      end else begin
        // gap or underrun: sync high, line idle, next word opens a burst
        rx_active <= 1'b0;
        rx_serial_data <= modem_port_pkg::IDLE_DATA;
        rx_burst_sync_n <= modem_port_pkg::SYNC_INACTIVE;
      end
    end
  end

endmodule

// File: dv/modem_port_assertions.sv
module modem_port_assertions #(
  parameter int BIT_CLOCK_HALF = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic [15:0] nv_config_addr,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic rx_serial_data,
  input wire logic rx_burst_sync_n,
  input wire logic tx_word_valid,
  input wire logic config_done,
  input wire logic continuous_mode,
  input wire logic [7:0] burst_length,
  input wire logic backoff_adapt_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // link side
  // ****
  int half_cnt;
  logic prev_clock;
  logic seen;
  // the first toggle after reset has no reference, so it only arms the check
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_cnt <= 0;
      prev_clock <= 1'b0;
      seen <= 1'b0;
    end else begin
      prev_clock <= tx_bit_clock;
      half_cnt <= (tx_bit_clock != prev_clock) ? 1 : half_cnt + 1;
      seen <= seen | (tx_bit_clock != prev_clock);
    end
  end
  sequence rx_clock_fall;
    $fell(rx_bit_clock);
  endsequence
  a_clocks_paired: assert property (@(posedge link_clk) disable iff (!rst_b)
    rx_bit_clock == tx_bit_clock) else $error("bit clocks differ");
  a_half_period: assert property (@(posedge link_clk) disable iff (!rst_b)
    seen && tx_bit_clock != prev_clock |-> half_cnt == BIT_CLOCK_HALF) else $error("bit clock half period wrong");
  a_data_on_fall: assert property (@(posedge link_clk) disable iff (!rst_b)
    $changed(rx_serial_data) |-> rx_clock_fall) else $error("receive data moved off the falling edge");
  a_sync_on_fall: assert property (@(posedge link_clk) disable iff (!rst_b)
    $changed(rx_burst_sync_n) |-> rx_clock_fall) else $error("receive sync moved off the falling edge");
  // ****
  // system side
  // ****
  a_continuous_no_sync: assert property (@(posedge clk) disable iff (!rst_b)
    continuous_mode |-> rx_burst_sync_n) else $error("sync active in continuous mode");
  a_burst_no_adapt: assert property (@(posedge clk) disable iff (!rst_b)
    !continuous_mode |-> !backoff_adapt_enable) else $error("adaptation on in burst mode");
  a_config_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    config_done && $past(config_done) |-> $stable(continuous_mode) && $stable(burst_length))
    else $error("configuration changed while running");
  a_storage_addr: assert property (@(posedge clk) disable iff (!rst_b)
    nv_config_addr == modem_port_pkg::BURST_LENGTH_ADDR) else $error("wrong storage address");
  a_idle_unconfigured: assert property (@(posedge clk) disable iff (!rst_b)
    !config_done |-> rx_burst_sync_n && rx_serial_data) else $error("receive side not idle before config");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    tx_word_valid |=> !tx_word_valid) else $error("word valid longer than one cycle");
endmodule

bind modem_dte_serial_burst_port modem_port_assertions #(.BIT_CLOCK_HALF(BIT_CLOCK_HALF)) checker_i (
  .clk, .rst_b, .link_clk, .nv_config_addr, .tx_bit_clock, .rx_bit_clock, .rx_serial_data, .rx_burst_sync_n,
  .tx_word_valid, .config_done, .continuous_mode, .burst_length, .backoff_adapt_enable);

// File: dv/dte_model.sv
module dte_model (
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic rx_serial_data,
  input wire logic rx_burst_sync_n,
  output logic tx_serial_data,
  output logic tx_burst_sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit 8 asks for an active sync on the word's first bit
  logic [8:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [8:0] cur;
  logic [7:0] rx_sh;
  int tx_idx = -1;
  int rx_cnt = -1;
  initial begin
    tx_serial_data = 1'b0;
    tx_burst_sync_n = 1'b1;
  end
  // sync idles high, stale data toggles
  always @(posedge tx_bit_clock) begin
    if (tx_idx < 0 && tx_q.size() > 0) begin
      cur = tx_q.pop_front();
      tx_idx = 7;
    end
    if (tx_idx >= 0) begin
      tx_serial_data <= cur[tx_idx];
      tx_burst_sync_n <= !(cur[8] && tx_idx == 7);
      tx_idx--;
    end else begin
      tx_serial_data <= !tx_serial_data;
      tx_burst_sync_n <= 1'b1;
    end
  end
  always @(posedge rx_bit_clock) begin
    if (!rx_burst_sync_n) rx_cnt = 0;
    if (rx_cnt >= 0) begin
      rx_sh = {rx_sh[6:0], rx_serial_data};
      rx_cnt++;
    end
    if (rx_cnt == 8) begin
      rx_q.push_back(rx_sh);
      rx_cnt = -1;
    end
  end
endmodule

// File: dv/modem_dte_serial_burst_port_test.sv
module modem_dte_serial_burst_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, link_clk, acquisition_mode_switch, tx_bit_clock, tx_serial_data, tx_burst_sync_n;
  logic rx_bit_clock, rx_serial_data, rx_burst_sync_n, tx_word_first, tx_word_valid, rx_word_first;
  logic rx_word_valid, rx_word_ready, config_done, continuous_mode, backoff_adapt_enable;
  logic [15:0] nv_config_addr;
  logic [7:0] nv_config_data, tx_word, rx_word, burst_length, w;
  logic f, ok;
  int miscompares = 0;
  int samples_checked = 0;
  modem_dte_serial_burst_port #(.BIT_CLOCK_HALF(4)) dut (.clk, .rst_b, .link_clk, .acquisition_mode_switch,
    .nv_config_addr, .nv_config_data, .tx_bit_clock, .tx_serial_data, .tx_burst_sync_n, .rx_bit_clock,
    .rx_serial_data, .rx_burst_sync_n, .tx_word, .tx_word_first, .tx_word_valid, .rx_word, .rx_word_first,
    .rx_word_valid, .rx_word_ready, .config_done, .continuous_mode, .burst_length, .backoff_adapt_enable);
  dte_model dte (.tx_bit_clock, .rx_bit_clock, .rx_serial_data, .rx_burst_sync_n, .tx_serial_data,
    .tx_burst_sync_n);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // ****
  // shared tasks
  // ****
  task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timed_out(input string what);
    miscompares++;
    $display("unexpected at %0t: no %s", $time, what);
    conclude();
  endtask
  // reset is asynchronous in both domains, so two clk cycles also clear the link side
  task automatic do_reset(input logic mode, input logic [7:0] nv);
    int n;
    @(negedge clk);
    rst_b = 1'b0;
    acquisition_mode_switch = mode;
    nv_config_data = nv;
    repeat (2) @(negedge clk);
    compare(16'(burst_length), 16'h0040, "factory length");
    rst_b = 1'b1;
    for (n = 0; n < 100 && config_done !== 1'b1; n++) @(negedge clk);
    if (n == 100) timed_out("config");
    repeat (10) @(negedge clk);
  endtask
  task automatic get_tx(output logic [7:0] gw, output logic gf, output logic gok);
    int n;
    for (n = 0; n < 300 && tx_word_valid !== 1'b1; n++) @(negedge clk);
    gok = (n < 300);
    gw = tx_word;
    gf = tx_word_first;
    @(negedge clk);
  endtask
  task automatic send_rx(input logic [7:0] sw, input logic sf);
    int n;
    @(negedge clk);
    rx_word = sw;
    rx_word_first = sf;
    rx_word_valid = 1'b1;
    // ready comes from clk flops, so the level seen here still holds at the next rising edge
    for (n = 0; n < 500 && rx_word_ready !== 1'b1; n++) @(negedge clk);
    if (n == 500) timed_out("receive ready");
    @(negedge clk);
    rx_word_valid = 1'b0;
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_config_burst();
    do_reset(1'b0, 8'h02);
    compare(16'(continuous_mode), 16'h0000, "mode");
    compare(16'(burst_length), 16'h0002, "length");
    compare(16'(backoff_adapt_enable), 16'h0000, "adapt");
    compare(nv_config_addr, 16'h0200, "address");
    compare(16'(rx_burst_sync_n), 16'h0001, "idle sync");
    compare(16'(rx_word_ready), 16'h0001, "ready after config");
    $display("burst config test ended");
  endtask
  task automatic test_tx_burst();
    // mixed-bit words stand in for scrambled data
    dte.tx_q.push_back(9'h1a5);
    dte.tx_q.push_back(9'h03c);
    dte.tx_q.push_back(9'h0c7);
    get_tx(w, f, ok);
    compare({7'h00, ok, w}, 16'h01a5, "first word");
    compare(16'(f), 16'h0001, "first flag");
    get_tx(w, f, ok);
    compare({7'h00, ok, f, w[6:0]}, 16'h013c, "second word");
    get_tx(w, f, ok);
    compare(16'(ok), 16'h0000, "word past burst end");
    // idle guard bits before the next burst
    dte.tx_q.push_back(9'h1e7);
    get_tx(w, f, ok);
    compare({6'h00, ok, f, w}, 16'h03e7, "new burst");
    $display("transmit burst test ended");
  endtask
  task automatic test_rx_burst();
    int n;
    send_rx(8'hc3, 1'b1);
    send_rx(8'h5a, 1'b0);
    for (n = 0; n < 400 && dte.rx_q.size() < 2; n++) @(negedge clk);
    if (n == 400) timed_out("receive words");
    compare(16'(dte.rx_q.pop_front()), 16'h00c3, "received first");
    compare(16'(dte.rx_q.pop_front()), 16'h005a, "received second");
    $display("receive burst test ended");
  endtask
  task automatic test_continuous();
    do_reset(1'b1, 8'h10);
    compare({15'h0000, continuous_mode}, 16'h0001, "mode");
    compare({15'h0000, backoff_adapt_enable}, 16'h0001, "adapt");
    acquisition_mode_switch = 1'b0;
    nv_config_data = 8'h33;
    repeat (20) @(negedge clk);
    compare({7'h00, continuous_mode, burst_length}, 16'h0110, "frozen config");
    get_tx(w, f, ok);
    compare(16'(ok), 16'h0001, "word without sync");
    send_rx(8'h81, 1'b1);
    repeat (200) @(negedge clk);
    compare(16'(dte.rx_q.size()), 16'h0000, "sync in continuous");
    $display("continuous test ended");
  endtask
  initial begin
    rst_b = 1'b0;
    acquisition_mode_switch = 1'b0;
    nv_config_data = 8'h40;
    rx_word = 8'h00;
    rx_word_first = 1'b0;
    rx_word_valid = 1'b0;
    test_config_burst();
    test_tx_burst();
    test_rx_burst();
    test_continuous();
    conclude();
  end
endmodule
